// ===== design/cp_lock_detect_config_regs.sv
// charge pump and lock detector configuration bank with its lock counters
`timescale 1ns/1ps
`include "cp_lock_detect_consts.svh"
module cp_lock_detect_config_regs (
    input  wire logic        sys_clk,
    input  wire logic        nrst,
    input  wire logic        regWrStrobe,
    input  wire logic        regRdStrobe,
    input  wire logic [7:0]  regAddr,
    input  wire logic [31:0] regWrData,
    output logic [31:0]      regRdData,
    output logic             regRdValid,
    input  wire logic        pfdEnable,
    input  wire logic        ldPulseValid,
    input  wire logic [6:0]  ldPulseWidth,
    input  wire logic        ldRefFirst,
    input  wire logic        phaseValid,
    input  wire logic [15:0] phaseErrPs,
    input  wire logic        phaseRefLeads,
    input  wire logic        osSampleValid,
    input  wire logic        osSampleInWindow,
    output logic [6:0]       pumpUpCode,
    output logic [6:0]       pumpDownCode,
    output logic [6:0]       pumpOffsetCode,
    output logic             pumpOffsetUp,
    output logic             pumpOffsetDown,
    output logic             pumpHighGain,
    output logic [1:0]       pumpOpampBias,
    output logic             pump_force_up,
    output logic             pump_force_down,
    output logic             pumpMidRail,
    output logic             pumpRingTest,
    output logic [2:0]       pumpHiZ,
    output logic             refEdgeRising,
    output logic             flexForceUp,
    output logic             flexForceDown,
    output logic [2:0]       oneShotPulseWidth,
    output logic [1:0]       ringSpeed,
    output logic             ringForce,
    output logic             oneShotDigital,
    output logic             lock_detector_locked,
    output logic             one_shot_lock_detector_locked
);
    logic [31:0] cpReg_q;
    logic [31:0] cpReg_d;
    logic [31:0] lwReg_q;
    logic [31:0] ltReg_q;
    logic [31:0] lgReg_q;
    logic        hitCp;
    logic        hitLw;
    logic        hitLt;
    logic        hitLg;
    logic [31:0] rdMux;
    logic [31:0] regRdData_q;
    logic        regRdValid_q;
    logic        midRail_q;
    logic [2:0]  hiZ_q;
    logic        flexUp_q;
    logic        flexDown_q;
    logic        pfdEnable_q;
    logic        forceUpNext;
    logic        forceDownNext;
    logic        beyondTh;
    logic [15:0] flexThPs;
    cp_lock_detect_pkg::flex_mode_e flexMode;
    cp_lock_detect_pkg::cur_code_t  upNext;
    cp_lock_detect_pkg::cur_code_t  downNext;
    cp_lock_detect_pkg::cur_code_t  offsetNext;

    // address decode; unmapped writes are dropped, unmapped reads give zero
    assign hitCp = regAddr == `ADDR_CHARGE_PUMP;
    assign hitLw = regAddr == `ADDR_LOCK_WINDOW;
    assign hitLt = regAddr == `ADDR_LOCK_THRESH;
    assign hitLg = regAddr == `ADDR_LEGACY_LOCK;

    assign rdMux = hitCp ? cpReg_q :
                   hitLw ? lwReg_q :
                   hitLt ? ltReg_q :
                   hitLg ? lgReg_q : 32'h00000000;

    assign cpReg_d = (regWrStrobe && hitCp) ? (regWrData & `MASK_CHARGE_PUMP) : cpReg_q;

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            cpReg_q <= `RST_CHARGE_PUMP;
            lwReg_q <= `RST_LOCK_WINDOW;
            ltReg_q <= `RST_LOCK_THRESH;
            lgReg_q <= `RST_LEGACY_LOCK;
        end else begin
            cpReg_q <= cpReg_d;
            if (regWrStrobe && hitLw) begin
                lwReg_q <= regWrData & `MASK_LOCK_WINDOW;
            end
            if (regWrStrobe && hitLt) begin
                ltReg_q <= regWrData & `MASK_LOCK_THRESH;
            end
            if (regWrStrobe && hitLg) begin
                lgReg_q <= regWrData & `MASK_LEGACY_LOCK;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            regRdData_q  <= 32'h00000000;
            regRdValid_q <= 1'b0;
        end else begin
            regRdValid_q <= regRdStrobe;
            if (regRdStrobe) begin
                regRdData_q <= rdMux;
            end
        end
    end

    assign regRdData  = regRdData_q;
    assign regRdValid = regRdValid_q;

    // pump fields come straight from the register flops
    assign pumpUpCode      = cpReg_q[`CP_UP_CODE_LSB +: 7];
    assign pumpDownCode    = cpReg_q[`CP_DOWN_CODE_LSB +: 7];
    assign pumpOffsetCode  = cpReg_q[`CP_OFFSET_CODE_LSB +: 7];
    assign pumpOffsetUp    = cpReg_q[`CP_OFFSET_UP_BIT];
    assign pumpOffsetDown  = cpReg_q[`CP_OFFSET_DOWN_BIT];
    assign pumpHighGain    = cpReg_q[`CP_HIGH_GAIN_BIT];
    assign pumpOpampBias   = cpReg_q[`CP_BIAS_LSB +: 2];
    assign pump_force_up   = cpReg_q[`PUMP_FORCE_UP_BIT];
    assign pump_force_down = cpReg_q[`CP_FORCE_DOWN_BIT];
    assign pumpRingTest    = cpReg_q[`CP_RING_TO_PUMP_BIT];

    // derived pump controls are built from the next register value so they
    // line up with the fields above in the same cycle
    assign upNext     = cpReg_d[`CP_UP_CODE_LSB +: 7];
    assign downNext   = cpReg_d[`CP_DOWN_CODE_LSB +: 7];
    assign offsetNext = cpReg_d[`CP_OFFSET_CODE_LSB +: 7];

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            midRail_q   <= 1'b0;
            hiZ_q       <= 3'h0;
            pfdEnable_q <= 1'b0;
        end else begin
            midRail_q   <= cpReg_d[`CP_MID_RAIL_BIT] && !cpReg_d[`PUMP_FORCE_UP_BIT]
                           && !cpReg_d[`CP_FORCE_DOWN_BIT];
            pfdEnable_q <= pfdEnable;
            // a zero code only floats the output while the detector is off
            hiZ_q       <= {offsetNext == 7'h00, downNext == 7'h00, upNext == 7'h00}
                           & {3{!pfdEnable}};
        end
    end

    assign pumpMidRail = midRail_q;
    assign pumpHiZ     = hiZ_q;

    // flex forcing: hold the last verdict until the next phase sample; FLEX_OFF clears it at once
    assign flexMode = cp_lock_detect_pkg::flex_mode_e'(lwReg_q[`LW_FLEX_LSB +: 2]);

    always_comb begin
        flexThPs = 16'h0000;
        unique case (flexMode)
            cp_lock_detect_pkg::FLEX_OFF: flexThPs = 16'hffff;
            cp_lock_detect_pkg::FLEX_1NS: flexThPs = 16'(`FLEX_TH1_NS * `PS_PER_NS);
            cp_lock_detect_pkg::FLEX_3NS: flexThPs = 16'(`FLEX_TH2_NS * `PS_PER_NS);
            cp_lock_detect_pkg::FLEX_5NS: flexThPs = 16'(`FLEX_TH3_NS * `PS_PER_NS);
        endcase
    end

    assign beyondTh      = (flexMode != cp_lock_detect_pkg::FLEX_OFF) && (phaseErrPs > flexThPs);
    assign forceUpNext   = beyondTh && phaseRefLeads;
    assign forceDownNext = beyondTh && !phaseRefLeads;

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            flexUp_q   <= 1'b0;
            flexDown_q <= 1'b0;
        end else if (phaseValid) begin
            flexUp_q   <= forceUpNext;
            flexDown_q <= forceDownNext;
        end else if (flexMode == cp_lock_detect_pkg::FLEX_OFF) begin
            flexUp_q   <= 1'b0;
            flexDown_q <= 1'b0;
        end
    end

    assign flexForceUp   = flexUp_q;
    assign flexForceDown = flexDown_q;

    assign refEdgeRising     = lwReg_q[`LW_REF_EDGE_BIT];
    assign oneShotPulseWidth = lgReg_q[`LG_PULSE_WIDTH_LSB +: 3];
    assign ringSpeed         = lgReg_q[`LG_RING_SPEED_LSB +: 2];
    assign ringForce         = lgReg_q[`LG_RING_FORCE_BIT];
    assign oneShotDigital    = lgReg_q[`LG_ONE_SHOT_SEL_BIT];

    // main detector: window check then consecutive counter
    lock_sample_if mainSample ();
    lock_sample_if legacySample ();

    pulse_window #(
        .WIDTH (7)
    ) u_main_window (
        .sys_clk          (sys_clk),
        .nrst             (nrst),
        .pulseValid       (ldPulseValid),
        .pulseWidth       (ldPulseWidth),
        .refFirst         (ldRefFirst),
        .highThresh       (ltReg_q[`LT_HIGH_LSB +: 7]),
        .lowThresh        (ltReg_q[`LT_LOW_LSB +: 7]),
        .asymEnable       (lwReg_q[`LW_ASYM_EN_BIT]),
        .divFirstExpected (lwReg_q[`LW_ASYM_DIR_BIT]),
        .sample           (mainSample.src)
    );

    lock_counter #(
        .W (10)
    ) u_main_count (
        .sys_clk   (sys_clk),
        .nrst      (nrst),
        .sample    (mainSample.sink),
        .threshold (ltReg_q[`LT_COUNT_LSB +: 10]),
        .locked    (lock_detector_locked)
    );

    // legacy verdicts arrive from the one-shot already judged
    assign legacySample.valid    = osSampleValid;
    assign legacySample.inWindow = osSampleInWindow;

    lock_counter #(
        .W (16)
    ) u_legacy_count (
        .sys_clk   (sys_clk),
        .nrst      (nrst),
        .sample    (legacySample.sink),
        .threshold (lgReg_q[`LG_COUNT_LSB +: 16]),
        .locked    (one_shot_lock_detector_locked)
    );

    sequence s_cp_write;
        regWrStrobe && hitCp;
    endsequence

    a_cp_write: assert property (@(posedge sys_clk) disable iff (!nrst)
        s_cp_write |=> cpReg_q == ($past(regWrData) & `MASK_CHARGE_PUMP))
        else $error("charge pump register did not take write");

    a_cp_hold: assert property (@(posedge sys_clk) disable iff (!nrst)
        !(regWrStrobe && hitCp) |=> $stable(cpReg_q))
        else $error("pump register changed unasked");

    a_lw_write: assert property (@(posedge sys_clk) disable iff (!nrst)
        regWrStrobe && hitLw |=> lwReg_q == ($past(regWrData) & `MASK_LOCK_WINDOW))
        else $error("window register missed write");

    a_lw_hold: assert property (@(posedge sys_clk) disable iff (!nrst)
        !(regWrStrobe && hitLw) |=> $stable(lwReg_q))
        else $error("window register changed unasked");

    a_lt_write: assert property (@(posedge sys_clk) disable iff (!nrst)
        regWrStrobe && hitLt |=> ltReg_q == ($past(regWrData) & `MASK_LOCK_THRESH))
        else $error("threshold register missed write");

    a_lg_write: assert property (@(posedge sys_clk) disable iff (!nrst)
        regWrStrobe && hitLg |=> lgReg_q == ($past(regWrData) & `MASK_LEGACY_LOCK))
        else $error("legacy register missed write");

    a_read_back: assert property (@(posedge sys_clk) disable iff (!nrst)
        regRdStrobe && hitLt |=> regRdValid && regRdData == $past(ltReg_q))
        else $error("threshold register read back wrong");

    a_rd_pulse: assert property (@(posedge sys_clk) disable iff (!nrst)
        regRdStrobe |=> regRdValid)
        else $error("read valid missing");

    a_rd_quiet: assert property (@(posedge sys_clk) disable iff (!nrst)
        !regRdStrobe |=> !regRdValid)
        else $error("read valid without strobe");

    a_unmapped_zero: assert property (@(posedge sys_clk) disable iff (!nrst)
        regRdStrobe && !(hitCp || hitLw || hitLt || hitLg) |=> regRdData == 32'h00000000)
        else $error("unmapped read not zero");

    a_mid_priority: assert property (@(posedge sys_clk) disable iff (!nrst)
        pumpMidRail |-> !pump_force_up && !pump_force_down && cpReg_q[`CP_MID_RAIL_BIT])
        else $error("mid rail with a force active");

    a_mid_set: assert property (@(posedge sys_clk) disable iff (!nrst)
        cpReg_q[`CP_MID_RAIL_BIT] && !pump_force_up && !pump_force_down |-> pumpMidRail)
        else $error("mid rail not driven");

    a_hiz_enable: assert property (@(posedge sys_clk) disable iff (!nrst)
        pumpHiZ[0] |-> pumpUpCode == 7'h00 && !$past(pfdEnable))
        else $error("tristate without zero code and disabled detector");

    a_hiz_codes: assert property (@(posedge sys_clk) disable iff (!nrst)
        !pfdEnable_q |-> pumpHiZ == {pumpOffsetCode == 7'h00, pumpDownCode == 7'h00,
                                     pumpUpCode == 7'h00})
        else $error("zero code not tristated");

    a_hiz_off: assert property (@(posedge sys_clk) disable iff (!nrst)
        pfdEnable_q |-> pumpHiZ == 3'h0)
        else $error("tristate while detector enabled");

    a_flex_up: assert property (@(posedge sys_clk) disable iff (!nrst)
        phaseValid && flexMode == cp_lock_detect_pkg::FLEX_3NS && phaseErrPs > 16'd3000
        && phaseRefLeads |=> flexForceUp && !flexForceDown)
        else $error("flex force up missing beyond 3 ns");

    a_flex_down: assert property (@(posedge sys_clk) disable iff (!nrst)
        phaseValid && flexMode == cp_lock_detect_pkg::FLEX_5NS && phaseErrPs > 16'd5000
        && !phaseRefLeads |=> flexForceDown && !flexForceUp)
        else $error("flex force down missing beyond 5 ns");

    a_flex_quiet: assert property (@(posedge sys_clk) disable iff (!nrst)
        phaseValid && flexMode == cp_lock_detect_pkg::FLEX_1NS && phaseErrPs <= 16'd1000
        |=> !flexForceUp && !flexForceDown)
        else $error("flex forcing inside 1 ns");

    a_flex_hold: assert property (@(posedge sys_clk) disable iff (!nrst)
        !phaseValid && flexMode != cp_lock_detect_pkg::FLEX_OFF
        |=> $stable(flexForceUp) && $stable(flexForceDown))
        else $error("flex verdict moved between samples");

    a_flex_off: assert property (@(posedge sys_clk) disable iff (!nrst)
        flexMode == cp_lock_detect_pkg::FLEX_OFF |=> !flexForceUp && !flexForceDown)
        else $error("flex forcing while disabled");
endmodule // cp_lock_detect_config_regs

// ===== design/cp_lock_detect_consts.svh
// register offsets, field positions, reset values and thresholds of the pump and lock bank
`ifndef CP_LOCK_DETECT_CONSTS_SVH
`define CP_LOCK_DETECT_CONSTS_SVH

`define ADDR_CHARGE_PUMP      8'h04
`define ADDR_LOCK_WINDOW      8'h05
`define ADDR_LOCK_THRESH      8'h06
`define ADDR_LEGACY_LOCK      8'h07

`define MASK_CHARGE_PUMP      32'h3fffffff
`define MASK_LOCK_WINDOW      32'h0000001f
`define MASK_LOCK_THRESH      32'h00ffffff
`define MASK_LEGACY_LOCK      32'h007fffff

`define RST_CHARGE_PUMP       32'h0301c387
`define RST_LOCK_WINDOW       32'h00000000
`define RST_LOCK_THRESH       32'h0080007f
`define RST_LEGACY_LOCK       32'h00441000

`define CP_UP_CODE_LSB        0
`define CP_DOWN_CODE_LSB      7
`define CP_OFFSET_CODE_LSB    14
`define CP_OFFSET_UP_BIT      21
`define CP_OFFSET_DOWN_BIT    22
`define CP_HIGH_GAIN_BIT      23
`define CP_BIAS_LSB           24
`define PUMP_FORCE_UP_BIT       26
`define CP_FORCE_DOWN_BIT     27
`define CP_MID_RAIL_BIT       28
`define CP_RING_TO_PUMP_BIT   29

`define LW_ASYM_EN_BIT        0
`define LW_ASYM_DIR_BIT       1
`define LW_REF_EDGE_BIT       2
`define LW_FLEX_LSB           3

`define LT_HIGH_LSB           0
`define LT_LOW_LSB            7
`define LT_COUNT_LSB          14

`define LG_COUNT_LSB          0
`define LG_PULSE_WIDTH_LSB    16
`define LG_RING_SPEED_LSB     19
`define LG_RING_FORCE_BIT     21
`define LG_ONE_SHOT_SEL_BIT   22

`define CODE_STEP_UA          20
`define OFFSET_STEP_UA        5
`define FLEX_TH1_NS           1
`define FLEX_TH2_NS           3
`define FLEX_TH3_NS           5
`define PS_PER_NS             1000

`endif

// ===== design/cp_lock_detect_pkg.sv
// types shared by the pump and lock bank
package cp_lock_detect_pkg;
    typedef logic [6:0] cur_code_t;
    typedef enum logic [1:0] {FLEX_OFF, FLEX_1NS, FLEX_3NS, FLEX_5NS} flex_mode_e;
endpackage

// ===== design/lock_counter.sv
// consecutive in-window counter that declares lock at a programmed count
`timescale 1ns/1ps
module lock_counter #(
    parameter int W = 10
) (
    input  wire logic         sys_clk,
    input  wire logic         nrst,
    lock_sample_if.sink       sample,
    input  wire logic [W-1:0] threshold,
    output logic              locked
);
    if (W < 1 || W > 16) begin : g_bad_width
        $error("lock_counter width out of range");
    end

    logic [W-1:0] count_q;
    logic [W-1:0] count_d;
    logic         locked_q;
    logic         atTop;

    // saturating at the threshold keeps a long lock from wrapping to unlock
    assign atTop   = count_q >= threshold;
    assign count_d = !sample.valid    ? count_q :
                     !sample.inWindow ? '0 :
                     atTop            ? count_q : count_q + 1'b1;

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            count_q  <= '0;
            locked_q <= 1'b0;
        end else begin
            count_q  <= count_d;
            locked_q <= sample.valid && (count_d >= threshold) ? 1'b1 :
                        sample.valid ? 1'b0 : locked_q;
        end
    end

    assign locked = locked_q;

    sequence s_last_good;
        sample.valid && sample.inWindow && (count_q + 1'b1 == threshold);
    endsequence

    a_lock_restart: assert property (@(posedge sys_clk) disable iff (!nrst)
        sample.valid && !sample.inWindow |=> count_q == '0)
        else $error("counter not restarted after out-of-window pulse");
    a_lock_reach: assert property (@(posedge sys_clk) disable iff (!nrst)
        s_last_good ##1 $stable(threshold) |-> locked)
        else $error("lock not declared at programmed count");
    a_lock_drop: assert property (@(posedge sys_clk) disable iff (!nrst)
        sample.valid && !sample.inWindow && threshold != '0 |=> !locked)
        else $error("lock held after out-of-window pulse");
endmodule // lock_counter

// ===== design/lock_sample_if.sv
// one lock detector sample: strobe plus in-window verdict
`timescale 1ns/1ps
interface lock_sample_if;
    logic valid;
    logic inWindow;
    modport src  (output valid, output inWindow);
    modport sink (input valid, input inWindow);
endinterface

// ===== design/pulse_window.sv
// checks a detector pulse against the programmed threshold window
`timescale 1ns/1ps
module pulse_window #(
    parameter int WIDTH = 7
) (
    input  wire logic             sys_clk,
    input  wire logic             nrst,
    input  wire logic             pulseValid,
    input  wire logic [WIDTH-1:0] pulseWidth,
    input  wire logic             refFirst,
    input  wire logic [WIDTH-1:0] highThresh,
    input  wire logic [WIDTH-1:0] lowThresh,
    input  wire logic             asymEnable,
    input  wire logic             divFirstExpected,
    lock_sample_if.src            sample
);
    if (WIDTH < 1 || WIDTH > 16) begin : g_bad_width
        $error("pulse_window width out of range");
    end

    logic inRange;
    logic orderOk;
    logic valid_q;
    logic inWindow_q;

    assign inRange = (pulseWidth >= lowThresh) && (pulseWidth <= highThresh);
    // asymmetric window also demands the expected edge order
    assign orderOk = !asymEnable || (refFirst != divFirstExpected);

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            valid_q    <= 1'b0;
            inWindow_q <= 1'b0;
        end else begin
            valid_q    <= pulseValid;
            inWindow_q <= pulseValid && inRange && orderOk;
        end
    end

    assign sample.valid    = valid_q;
    assign sample.inWindow = inWindow_q;

    a_window_high: assert property (@(posedge sys_clk) disable iff (!nrst)
        pulseValid && (pulseWidth > highThresh) |=> !sample.inWindow)
        else $error("pulse above high threshold counted in window");
    a_window_order: assert property (@(posedge sys_clk) disable iff (!nrst)
        pulseValid && asymEnable && (refFirst == divFirstExpected) |=> !sample.inWindow)
        else $error("wrong edge order counted in window");
endmodule // pulse_window

// ===== testbench/host_port_model.sv
// host side model that drives the parallel register port
`timescale 1ns/1ps
module host_port_model (
    input  wire logic        sys_clk,
    output logic             regWrStrobe,
    output logic             regRdStrobe,
    output logic [7:0]       regAddr,
    output logic [31:0]      regWrData,
    input  wire logic [31:0] regRdData,
    input  wire logic        regRdValid
);
    initial begin
        regWrStrobe = 1'b0;
        regRdStrobe = 1'b0;
        regAddr     = 8'h00;
        regWrData   = 32'h00000000;
    end

    // idle lines carry the inverse so a stale value never passes
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(negedge sys_clk);
        regAddr     = a;
        regWrData   = d;
        regWrStrobe = 1'b1;
        @(negedge sys_clk);
        regWrStrobe = 1'b0;
        regAddr     = ~a;
        regWrData   = ~d;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        int n;
        @(negedge sys_clk);
        regAddr     = a;
        regRdStrobe = 1'b1;
        @(negedge sys_clk);
        regRdStrobe = 1'b0;
        regAddr     = ~a;
        n = 0;
        while (regRdValid !== 1'b1 && n < 3) begin
            @(negedge sys_clk);
            n++;
        end
        d = (regRdValid === 1'b1) ? regRdData : 32'hdeadbeef;
    endtask
endmodule // host_port_model

// ===== testbench/tb_top.sv
// self-checking bench for the pump and lock configuration bank
`timescale 1ns/1ps
`include "cp_lock_detect_consts.svh"
module tb_top;
    logic        sys_clk, nrst, regWrStrobe, regRdStrobe, regRdValid, pfdEnable;
    logic        ldPulseValid, ldRefFirst, phaseValid, phaseRefLeads;
    logic        osSampleValid, osSampleInWindow, pumpOffsetUp, pumpOffsetDown, pumpHighGain;
    logic        pump_force_up, pump_force_down, pumpMidRail, pumpRingTest, refEdgeRising;
    logic        flexForceUp, flexForceDown, ringForce, oneShotDigital;
    logic        lock_detector_locked, one_shot_lock_detector_locked;
    logic [7:0]  regAddr;
    logic [31:0] regWrData, regRdData, rdv;
    logic [6:0]  ldPulseWidth, pumpUpCode, pumpDownCode, pumpOffsetCode;
    logic [15:0] phaseErrPs;
    logic [2:0]  pumpHiZ, oneShotPulseWidth;
    logic [1:0]  pumpOpampBias, ringSpeed;
    int          errTotal, compares, cyc;
    localparam logic [7:0]  ADDRS [4] = '{`ADDR_CHARGE_PUMP, `ADDR_LOCK_WINDOW,
                                         `ADDR_LOCK_THRESH, `ADDR_LEGACY_LOCK};
    localparam logic [31:0] RSTS [4]  = '{`RST_CHARGE_PUMP, `RST_LOCK_WINDOW,
                                         `RST_LOCK_THRESH, `RST_LEGACY_LOCK};
    localparam logic [31:0] MASKS [4] = '{`MASK_CHARGE_PUMP, `MASK_LOCK_WINDOW,
                                         `MASK_LOCK_THRESH, `MASK_LEGACY_LOCK};
    localparam logic [15:0] FLEX_PS [4] = '{0, 1000, 3000, 5000};

    host_port_model host_port_model_i (.sys_clk(sys_clk), .regWrStrobe(regWrStrobe),
        .regRdStrobe(regRdStrobe), .regAddr(regAddr), .regWrData(regWrData),
        .regRdData(regRdData), .regRdValid(regRdValid));

    cp_lock_detect_config_regs cp_lock_detect_config_regs_i (.sys_clk(sys_clk), .nrst(nrst),
        .regWrStrobe(regWrStrobe), .regRdStrobe(regRdStrobe), .regAddr(regAddr),
        .regWrData(regWrData), .regRdData(regRdData), .regRdValid(regRdValid),
        .pfdEnable(pfdEnable), .ldPulseValid(ldPulseValid), .ldPulseWidth(ldPulseWidth),
        .ldRefFirst(ldRefFirst), .phaseValid(phaseValid), .phaseErrPs(phaseErrPs),
        .phaseRefLeads(phaseRefLeads), .osSampleValid(osSampleValid),
        .osSampleInWindow(osSampleInWindow), .pumpUpCode(pumpUpCode),
        .pumpDownCode(pumpDownCode), .pumpOffsetCode(pumpOffsetCode),
        .pumpOffsetUp(pumpOffsetUp), .pumpOffsetDown(pumpOffsetDown),
        .pumpHighGain(pumpHighGain), .pumpOpampBias(pumpOpampBias),
        .pump_force_up(pump_force_up), .pump_force_down(pump_force_down),
        .pumpMidRail(pumpMidRail), .pumpRingTest(pumpRingTest), .pumpHiZ(pumpHiZ),
        .refEdgeRising(refEdgeRising), .flexForceUp(flexForceUp),
        .flexForceDown(flexForceDown), .oneShotPulseWidth(oneShotPulseWidth),
        .ringSpeed(ringSpeed), .ringForce(ringForce), .oneShotDigital(oneShotDigital),
        .lock_detector_locked(lock_detector_locked),
        .one_shot_lock_detector_locked(one_shot_lock_detector_locked));

    always #5 sys_clk = ~sys_clk;

    task automatic summarize();
        $display("compares=%0d errors=%0d", compares, errTotal);
        if (errTotal == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // whole run is under two hundred cycles, so this only catches a hang
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 5000) begin
            errTotal++;
            summarize();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            errTotal++;
            $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        host_port_model_i.wr(a, d);
        @(negedge sys_clk);
    endtask

    task automatic ld(input logic [6:0] w, input logic rf);
        @(negedge sys_clk);
        ldPulseWidth = w;
        ldRefFirst   = rf;
        ldPulseValid = 1'b1;
        @(negedge sys_clk);
        ldPulseValid = 1'b0;
    endtask

    // main verdict lands two cycles after the sample
    task automatic ldLock(input logic exp);
        repeat (3) @(negedge sys_clk);
        chk(lock_detector_locked, exp);
    endtask

    task automatic phase(input logic [15:0] e, input logic lead, input logic [1:0] ex);
        @(negedge sys_clk);
        phaseErrPs    = e;
        phaseRefLeads = lead;
        phaseValid    = 1'b1;
        @(negedge sys_clk);
        phaseValid = 1'b0;
        @(negedge sys_clk);
        chk({flexForceUp, flexForceDown}, ex);
    endtask

    task automatic os(input logic inw, input logic exp);
        @(negedge sys_clk);
        osSampleInWindow = inw;
        osSampleValid    = 1'b1;
        @(negedge sys_clk);
        osSampleValid = 1'b0;
        chk(one_shot_lock_detector_locked, exp);
    endtask

    initial begin
        {sys_clk, nrst, ldPulseValid, ldRefFirst, phaseValid, phaseRefLeads} = 6'h00;
        {osSampleValid, osSampleInWindow, ldPulseWidth, phaseErrPs} = 25'h0000000;
        pfdEnable = 1'b1;
        errTotal  = 0;
        compares  = 0;
        cyc       = 0;
        repeat (8) @(negedge sys_clk);
        nrst = 1'b1;
        chk(pumpOpampBias, 2'b11);
        chk(oneShotDigital, 1'b1);
        for (int i = 0; i < 4; i++) begin
            host_port_model_i.rd(ADDRS[i], rdv);
            chk(rdv, RSTS[i]);
            wr(ADDRS[i], 32'hffffffff);
            host_port_model_i.rd(ADDRS[i], rdv);
            chk(rdv, MASKS[i]);
        end
        wr(8'h03, 32'hffffffff);
        host_port_model_i.rd(8'h03, rdv);
        chk(rdv, 32'h00000000);
        wr(`ADDR_CHARGE_PUMP, {2'b00, 4'b1001, 2'b01, 3'b101, 7'h55, 7'h2a, 7'h7f});
        chk({pumpRingTest, pumpMidRail, pump_force_down, pump_force_up}, 4'b1001);
        chk({pumpOpampBias, pumpHighGain, pumpOffsetDown, pumpOffsetUp}, 5'h0d);
        chk({pumpOffsetCode, pumpDownCode, pumpUpCode}, {7'h55, 7'h2a, 7'h7f});
        wr(`ADDR_CHARGE_PUMP, {2'b00, 4'b0010, 2'b10, 3'b010, 7'h2a, 7'h55, 7'h01});
        chk({pumpRingTest, pump_force_down, pump_force_up, pumpOffsetDown}, 4'b0101);
        chk({pumpOffsetCode, pumpDownCode, pumpUpCode}, {7'h2a, 7'h55, 7'h01});
        for (int i = 0; i < 3; i++) begin
            wr(`ADDR_CHARGE_PUMP, 32'h10000000 | (32'h02000000 << i) & 32'h0c000000);
            chk(pumpMidRail, i == 0);
        end
        // tristate needs both a zero code and a stopped detector
        pfdEnable = 1'b0;
        wr(`ADDR_CHARGE_PUMP, 32'h00000001);
        chk(pumpHiZ, 3'b110);
        pfdEnable = 1'b1;
        repeat (2) @(negedge sys_clk);
        chk(pumpHiZ, 3'b000);
        for (int m = 1; m < 4; m++) begin
            wr(`ADDR_LOCK_WINDOW, {27'h0, m[1:0], 3'b100});
            chk(refEdgeRising, 1'b1);
            phase(FLEX_PS[m], 1'b1, 2'b00);
            phase(FLEX_PS[m] + 16'd1, 1'b1, 2'b10);
            phase(FLEX_PS[m] + 16'd1, 1'b0, 2'b01);
        end
        wr(`ADDR_LOCK_WINDOW, 32'h00000000);
        chk(refEdgeRising, 1'b0);
        phase(16'hffff, 1'b1, 2'b00);
        wr(`ADDR_LOCK_THRESH, (32'd3 << 14) | (32'd2 << 7) | 32'd10);
        ld(7'd5, 1'b1);
        ld(7'd10, 1'b1);
        ldLock(1'b0);
        ld(7'd11, 1'b1);
        ld(7'd2, 1'b1);
        ld(7'd5, 1'b1);
        ldLock(1'b0);
        ld(7'd5, 1'b1);
        ldLock(1'b1);
        ld(7'd1, 1'b1);
        ldLock(1'b0);
        for (int dir = 0; dir < 2; dir++) begin
            wr(`ADDR_LOCK_WINDOW, {30'h0, dir[0], 1'b1});
            repeat (3) ld(7'd5, ~dir[0]);
            ldLock(1'b1);
            ld(7'd5, dir[0]);
            ldLock(1'b0);
        end
        wr(`ADDR_LEGACY_LOCK, {9'h0, 1'b0, 1'b1, 2'b11, 3'b010, 16'd2});
        chk({oneShotDigital, ringForce, ringSpeed, oneShotPulseWidth}, 7'h3a);
        os(1'b1, 1'b0);
        os(1'b1, 1'b1);
        os(1'b0, 1'b0);
        summarize();
    end
endmodule // tb_top
